/* src/pmes_event_status_bank.sv */
// How it works
// - each byte lane of the status word is read and written on its own
// - bits not present in this block read zero and ignore writes
// - the block sits at its own 32-bit aligned address
// - status clears on the edge working state is entered from soft-off
// - counter msb change in either direction sets timer carry flag
// - timer carry flag with its enable raises an event
// - bus master request sets activity flag, cleared by writing one or on entry to working from soft-off
// - firmware attention pulse sets firmware attention flag
// - power button press sets flag; working-state event while enabled
// - power button press while sleeping or off always wakes
// - button held over four seconds clears flag and forces soft-off
// - power button flag already set on wake from sleep
// - sleep button sets flag; event when enabled; wakes only when enabled
// - sleep button flag set before wake completes
// - alarm sets alarm flag; enabled alarm raises an event
// - alarm wakes from sleep one to three, four only when capable
// - reserved bits read zero, bit eleven reads zero
// - enabled wake while sleeping sets wake flag and requests working on the same edge
// - events route to control interrupt when select set, else management
`timescale 1ns/100ps
`include "pmes_regs.svh"

module pmes_event_status_bank #(
	parameter logic [15:0] BLOCK_BASE = 16'h0400,
	parameter logic [15:0] IMPL_MASK = 16'hFFFF,
	parameter int unsigned OVERRIDE_CYCLES = `PMES_OVERRIDE_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [15:0] ioAddr,
	input wire logic ioRd,
	input wire logic ioWr,
	input wire logic [1:0] ioByteEn,
	input wire logic [15:0] ioWrData,
	output logic [15:0] ioRdData,
	output logic ioRdAck,
	input wire logic powerButton,
	input wire logic sleepButton,
	input wire logic alarmIrq,
	input wire logic busMasterReq,
	input wire logic counterMsb,
	input wire logic firmwareAttention,
	input wire logic timer_carry_enable,
	input wire logic firmware_attention_enable,
	input wire logic power_button_enable,
	input wire logic sleep_button_enable,
	input wire logic alarm_enable,
	input wire logic event_route_select,
	input wire logic alarm_wake_deep_sleep_capable,
	input wire pmes_pkg::pmes_state_e powerState,
	output logic sciEvent,
	output logic smiEvent,
	output logic wakeRequest,
	output logic forceSoftOff
);
	import pmes_pkg::*;

	localparam logic [15:0] LIVE_MASK = IMPL_MASK & `PMES_FLAG_MASK;
	localparam logic [27:0] OVERRIDE_LIMIT = 28'(OVERRIDE_CYCLES);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		pmes_word_t flags;
		logic prevMsb;
		pmes_state_e prevState;
		logic [27:0] holdCount;
		logic overrideDone;
		logic [15:0] rdData;
		logic rdAck;
		logic sci;
		logic smi;
		logic wake;
		logic softOff;
	} pmes_bank_s;

	pmes_bank_s st;
	pmes_bank_s next_st;

	pmes_sync_if syncIf ();

	// button, alarm and bus request synchronisers
	assign syncIf.raw[`PMES_IN_POWERBTN] = powerButton;
	assign syncIf.raw[`PMES_IN_SLEEPBTN] = sleepButton;
	assign syncIf.raw[`PMES_IN_ALARM] = alarmIrq;
	assign syncIf.raw[`PMES_IN_BUSREQ] = busMasterReq;

	pmes_sync u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.syncIf(syncIf)
	);

	function automatic logic block_hit(input logic [15:0] addr);
		block_hit = (addr[15:2] == BLOCK_BASE[15:2]) && (addr[1:0] == 2'b00);
	endfunction : block_hit

	// byte lanes expanded to bit mask
	function automatic logic [15:0] lane_mask(input logic [1:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction : lane_mask

	// ****************************************
	// next state
	// ****************************************
	logic sleeping;
	logic working;
	logic [15:0] setBits;
	logic [15:0] clrBits;
	logic wakeCause;
	logic overrideFire;
	logic event_any;

	always_comb begin
		next_st = st;
		working = (st.prevState == PMES_WORKING);
		sleeping = !working;
		setBits = '0;
		clrBits = '0;
		wakeCause = 1'b0;
		overrideFire = 1'b0;
		event_any = 1'b0;

		setBits[`PMES_BIT_TIMER] = (counterMsb != st.prevMsb);
		setBits[`PMES_BIT_BUSMASTER] = syncIf.rise[`PMES_IN_BUSREQ];
		setBits[`PMES_BIT_FIRMWARE] = firmwareAttention;
		// power button flag set in every state
		setBits[`PMES_BIT_POWERBTN] = syncIf.rise[`PMES_IN_POWERBTN];
		setBits[`PMES_BIT_SLEEPBTN] = syncIf.rise[`PMES_IN_SLEEPBTN];
		setBits[`PMES_BIT_ALARM] = syncIf.rise[`PMES_IN_ALARM];

		if (sleeping) begin
			wakeCause = syncIf.rise[`PMES_IN_POWERBTN]
				|| (syncIf.rise[`PMES_IN_SLEEPBTN] && sleep_button_enable);
			unique case (st.prevState)
				PMES_SLEEP1, PMES_SLEEP2, PMES_SLEEP3: begin
					wakeCause = wakeCause || (syncIf.rise[`PMES_IN_ALARM] && alarm_enable);
				end
				PMES_SLEEP4: begin
					wakeCause = wakeCause || (syncIf.rise[`PMES_IN_ALARM] && alarm_enable
						&& alarm_wake_deep_sleep_capable);
				end
				default: begin
					wakeCause = wakeCause;
				end
			endcase
		end
		setBits[`PMES_BIT_WAKE] = wakeCause;

		if (syncIf.level[`PMES_IN_POWERBTN]) begin
			if (!st.overrideDone) begin
				if (st.holdCount >= OVERRIDE_LIMIT - 28'h0000001) begin
					overrideFire = 1'b1;
					next_st.overrideDone = 1'b1;
				end else begin
					next_st.holdCount = st.holdCount + 28'h0000001;
				end
			end
		end else begin
			next_st.holdCount = '0;
			next_st.overrideDone = 1'b0;
		end

		// write one clears only selected lanes
		if (ioWr && block_hit(ioAddr)) begin
			clrBits = ioWrData & lane_mask(ioByteEn);
		end
		if (overrideFire) begin
			clrBits[`PMES_BIT_POWERBTN] = 1'b1;
		end

		if (powerState == PMES_WORKING && st.prevState == PMES_SOFT_OFF) begin
			clrBits = 16'hFFFF;
		end

		// set wins; absent bits stay zero
		next_st.flags = ((st.flags & ~clrBits) | setBits) & LIVE_MASK;
		next_st.prevMsb = counterMsb;
		next_st.prevState = powerState;

		next_st.rdAck = ioRd && block_hit(ioAddr);
		next_st.rdData = next_st.rdAck ? (st.flags & LIVE_MASK & lane_mask(ioByteEn)) : 16'h0000;

		if (working) begin
			event_any = (st.flags[`PMES_BIT_TIMER] && timer_carry_enable)
				|| (st.flags[`PMES_BIT_FIRMWARE] && firmware_attention_enable)
				|| (st.flags[`PMES_BIT_POWERBTN] && power_button_enable)
				|| (st.flags[`PMES_BIT_SLEEPBTN] && sleep_button_enable)
				|| (st.flags[`PMES_BIT_ALARM] && alarm_enable);
		end
		next_st.sci = event_any && event_route_select;
		next_st.smi = event_any && !event_route_select;
		next_st.wake = wakeCause;
		next_st.softOff = overrideFire;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ioRdData = st.rdData;
	assign ioRdAck = st.rdAck;
	assign sciEvent = st.sci;
	assign smiEvent = st.smi;
	assign wakeRequest = st.wake;
	assign forceSoftOff = st.softOff;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	reserved_read_a : assert property (ioRdAck |-> (ioRdData & ~LIVE_MASK) == 16'h0000)
		else $error("reserved or absent bit read as one");
	absent_bits_a : assert property ((st.flags & ~LIVE_MASK) == 16'h0000)
		else $error("absent bit holds a one");
	timer_set_a : assert property (LIVE_MASK[0] && $changed(counterMsb) |=> st.flags[0])
		else $error("timer carry flag not set after msb change");
	firmware_set_a : assert property (LIVE_MASK[5] && firmwareAttention |=> st.flags[5])
		else $error("firmware attention flag not set");
	set_wins_a : assert property (LIVE_MASK[4] && syncIf.rise[3] && ioWr && block_hit(ioAddr)
		&& ioByteEn[0] && ioWrData[4] |=> st.flags[4])
		else $error("clear beat a same-cycle set");
	w1c_clear_a : assert property (ioWr && block_hit(ioAddr) && ioByteEn[0] && ioWrData[4]
		&& !syncIf.rise[3] && powerState == st.prevState |=> !st.flags[4])
		else $error("write one failed to clear bus master flag");
	zero_write_a : assert property (st.flags[4] && !(ioWr && ioWrData[4] && ioByteEn[0])
		&& !(powerState == PMES_WORKING && st.prevState == PMES_SOFT_OFF) |=> st.flags[4])
		else $error("flag lost without a write of one");
	entry_clear_a : assert property (powerState == PMES_WORKING && st.prevState == PMES_SOFT_OFF
		&& setBits == 16'h0000 |=> st.flags == 16'h0000)
		else $error("status not cleared on entry to working");
	route_sci_a : assert property (st.prevState == PMES_WORKING && st.flags[0]
		&& timer_carry_enable |=> (sciEvent == $past(event_route_select))
		&& (smiEvent == !$past(event_route_select)))
		else $error("timer event routed to the wrong interrupt");
	no_event_sleep_a : assert property (st.prevState != PMES_WORKING
		|=> !sciEvent && !smiEvent)
		else $error("interrupt event raised outside working state");
	power_wake_a : assert property (st.prevState != PMES_WORKING && syncIf.rise[0]
		|=> wakeRequest && (st.flags[15] || !LIVE_MASK[15]))
		else $error("power button did not wake");
	sleep_gate_a : assert property (st.prevState != PMES_WORKING && !sleep_button_enable
		&& !syncIf.rise[0] && !syncIf.rise[2] |=> !wakeRequest)
		else $error("disabled sleep button caused a wake");
	deep_alarm_a : assert property (st.prevState == PMES_SLEEP4 && !alarm_wake_deep_sleep_capable
		&& !syncIf.rise[0] && !(syncIf.rise[1] && sleep_button_enable) |=> !wakeRequest)
		else $error("alarm woke deep sleep without capability");
	wake_only_sleep_a : assert property (wakeRequest |-> $past(st.prevState) != PMES_WORKING)
		else $error("wake requested while working");
	override_a : assert property (forceSoftOff |-> !st.flags[8] && $past(syncIf.level[0]))
		else $error("override fired with flag still set");

	wake_seen_c : cover property (wakeRequest ##1 st.flags[15]);
	override_seen_c : cover property (forceSoftOff);
	sci_seen_c : cover property (sciEvent ##[1:20] smiEvent);
	deep_wake_c : cover property (st.prevState == PMES_SLEEP4 && wakeRequest);
endmodule : pmes_event_status_bank

/* src/pmes_regs.svh */
`ifndef PMES_REGS_SVH
`define PMES_REGS_SVH

// register placement inside the event block
`define PMES_STS_OFFSET 16'h0000
`define PMES_STS_RESET 16'h0000

// flag bit positions
`define PMES_BIT_TIMER 0
`define PMES_BIT_BUSMASTER 4
`define PMES_BIT_FIRMWARE 5
`define PMES_BIT_POWERBTN 8
`define PMES_BIT_SLEEPBTN 9
`define PMES_BIT_ALARM 10
`define PMES_BIT_WAKE 15

// bits that hold a flag; all others read zero
`define PMES_FLAG_MASK 16'h8731

// synchronised input lanes
`define PMES_IN_POWERBTN 0
`define PMES_IN_SLEEPBTN 1
`define PMES_IN_ALARM 2
`define PMES_IN_BUSREQ 3
`define PMES_IN_COUNT 4

// timing
`define PMES_CLK_HZ 40000000
`define PMES_OVERRIDE_MS 4000
`define PMES_OVERRIDE_CYCLES (`PMES_OVERRIDE_MS * (`PMES_CLK_HZ / 1000))

`endif

/* src/pmes_pkg.sv */
package pmes_pkg;

	// system power state as reported by the sequencer
	typedef enum logic [2:0] {
		PMES_WORKING = 3'b000,
		PMES_SLEEP1 = 3'b001,
		PMES_SLEEP2 = 3'b010,
		PMES_SLEEP3 = 3'b011,
		PMES_SLEEP4 = 3'b100,
		PMES_SOFT_OFF = 3'b101
	} pmes_state_e;

	typedef logic [15:0] pmes_word_t;

endpackage : pmes_pkg

/* src/pmes_sync_if.sv */
`timescale 1ns/100ps
`include "pmes_regs.svh"

interface pmes_sync_if;
	logic [`PMES_IN_COUNT-1:0] raw;
	logic [`PMES_IN_COUNT-1:0] level;
	logic [`PMES_IN_COUNT-1:0] rise;

	modport sync (input raw, output level, output rise);
	modport core (output raw, input level, input rise);
endinterface : pmes_sync_if

/* src/pmes_sync.sv */
`timescale 1ns/100ps
`include "pmes_regs.svh"

module pmes_sync (
	input wire logic core_clk,
	input wire logic resetn,
	pmes_sync_if.sync syncIf
);
	import pmes_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [`PMES_IN_COUNT-1:0] stage1;
		logic [`PMES_IN_COUNT-1:0] stage2;
		logic [`PMES_IN_COUNT-1:0] last;
	} pmes_sync_s;

	pmes_sync_s st;
	pmes_sync_s next_st;

	always_comb begin
		next_st = st;
		next_st.stage1 = syncIf.raw;
		next_st.stage2 = st.stage1;
		next_st.last = st.stage2;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign syncIf.level = st.stage2;
	assign syncIf.rise = st.stage2 & ~st.last;

	// ****************************************
	// checks
	// ****************************************
	rise_single_a : assert property (@(posedge core_clk) disable iff (!resetn)
		|syncIf.rise |=> (syncIf.rise & $past(syncIf.rise)) == '0)
		else $error("rise pulse lasted more than one cycle");
endmodule : pmes_sync

/* sim/test_pmes_event_status_bank.sv */
`timescale 1ns/100ps
module test_pmes_event_status_bank;
	import pmes_pkg::*;
	// ****************
	// signals
	// ****************
	localparam logic [15:0] BASE = 16'h0400;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] ioAddr = 16'h0000;
	logic ioRd = 1'b0;
	logic ioWr = 1'b0;
	logic [1:0] ioByteEn = 2'h0;
	logic [15:0] ioWrData = 16'h0000;
	logic [15:0] ioRdData;
	logic ioRdAck;
	logic [5:0] src = 6'h00;
	logic counterMsb = 1'b0;
	logic [4:0] en = 5'h00;
	logic routeSel = 1'b1;
	logic deepCap = 1'b0;
	pmes_state_e powerState = PMES_WORKING;
	logic sciEvent, smiEvent, wakeRequest, forceSoftOff;
	int miscompares = 0;
	int tests_run = 0;
	pmes_word_t d;
	logic k;
	logic [15:0] rowExp [6] = '{16'h0001, 16'h0010, 16'h0020, 16'h0100, 16'h0200, 16'h0400};
	pmes_event_status_bank #(.OVERRIDE_CYCLES(20)) i_pmes_event_status_bank (
		.core_clk(core_clk), .resetn(resetn), .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr),
		.ioByteEn(ioByteEn), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdAck(ioRdAck),
		.powerButton(src[3]), .sleepButton(src[4]), .alarmIrq(src[5]),
		.busMasterReq(src[1]), .counterMsb(counterMsb), .firmwareAttention(src[2]),
		.timer_carry_enable(en[0]), .firmware_attention_enable(en[1]),
		.power_button_enable(en[2]), .sleep_button_enable(en[3]), .alarm_enable(en[4]),
		.event_route_select(routeSel), .alarm_wake_deep_sleep_capable(deepCap),
		.powerState(powerState), .sciEvent(sciEvent), .smiEvent(smiEvent),
		.wakeRequest(wakeRequest), .forceSoftOff(forceSoftOff));
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	// ****************
	// tasks
	// ****************
	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// bus tasks use byte or word lanes only
	task rd(input logic [15:0] a, input logic [1:0] be, output pmes_word_t dt, output logic ak);
		@(posedge core_clk);
		ioRd <= 1'b1;
		ioAddr <= a;
		ioByteEn <= be;
		@(posedge core_clk);
		ioRd <= 1'b0;
		#1;
		dt = ioRdData;
		ak = ioRdAck;
	endtask : rd
	task wr(input logic [1:0] be, input logic [15:0] v);
		@(posedge core_clk);
		ioWr <= 1'b1;
		ioAddr <= BASE;
		ioByteEn <= be;
		ioWrData <= v;
		@(posedge core_clk);
		ioWr <= 1'b0;
	endtask : wr
	task pulse(input int i);
		@(posedge core_clk);
		if (i == 0) begin
			counterMsb <= ~counterMsb;
		end else begin
			src[i] <= 1'b1;
		end
		repeat (4) @(posedge core_clk);
		src <= 6'h00;
		repeat (4) @(posedge core_clk);
	endtask : pulse
	// ****************
	// tests
	// ****************
	initial begin
		#200us;
		miscompares++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		rd(BASE, 2'h3, d, k);
		chk(d, 16'h0000);
		chk({15'h0000, k}, 16'h0001);
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			rd(BASE, 2'h3, d, k);
			chk(d, rowExp[i]);
			wr(2'h3, 16'h0000);
			rd(BASE, 2'h3, d, k);
			chk(d, rowExp[i]);
			wr(2'h3, 16'hFFFF);
			rd(BASE, 2'h3, d, k);
			chk(d, 16'h0000);
		end
		pulse(1);
		pulse(4);
		rd(BASE, 2'h2, d, k);
		chk(d, 16'h0200);
		wr(2'h1, 16'hFFFF);
		rd(BASE, 2'h3, d, k);
		chk(d, 16'h0200);
		rd(16'h0402, 2'h3, d, k);
		chk(d, 16'h0000);
		chk({15'h0000, k}, 16'h0000);
		rd(16'h0404, 2'h3, d, k);
		chk(d, 16'h0000);
		chk({15'h0000, k}, 16'h0000);
		// bus request rise lands on the same edge as a write-one clear
		@(posedge core_clk);
		src[1] <= 1'b1;
		@(posedge core_clk);
		wr(2'h1, 16'h0010);
		src <= 6'h00;
		rd(BASE, 2'h3, d, k);
		chk(d, 16'h0210);
		wr(2'h3, 16'hFFFF);
		en <= 5'h01;
		pulse(0);
		chk({14'h0000, sciEvent, smiEvent}, 16'h0002);
		routeSel <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk({14'h0000, sciEvent, smiEvent}, 16'h0001);
		wr(2'h3, 16'h0001);
		repeat (3) @(posedge core_clk);
		chk({14'h0000, sciEvent, smiEvent}, 16'h0000);
		en <= 5'h10;
		powerState <= PMES_SLEEP3;
		repeat (3) @(posedge core_clk);
		@(posedge core_clk);
		src[5] <= 1'b1;
		k = 1'b0;
		for (int n = 0; n < 20; n++) begin
			@(posedge core_clk);
			#1;
			if (wakeRequest === 1'b1) k = 1'b1;
		end
		src <= 6'h00;
		chk({15'h0000, k}, 16'h0001);
		rd(BASE, 2'h3, d, k);
		chk(d, 16'h8400);
		powerState <= PMES_SOFT_OFF;
		repeat (3) @(posedge core_clk);
		powerState <= PMES_WORKING;
		repeat (4) @(posedge core_clk);
		rd(BASE, 2'h3, d, k);
		chk(d, 16'h0000);
		@(posedge core_clk);
		src[3] <= 1'b1;
		k = 1'b0;
		for (int n = 0; n < 60; n++) begin
			@(posedge core_clk);
			#1;
			if (forceSoftOff === 1'b1) k = 1'b1;
		end
		chk({15'h0000, k}, 16'h0001);
		rd(BASE, 2'h3, d, k);
		chk(d, 16'h0000);
		src <= 6'h00;
		repeat (4) @(posedge core_clk);
		// power button wakes deep sleep with its enable clear
		powerState <= PMES_SLEEP4;
		repeat (3) @(posedge core_clk);
		pulse(3);
		rd(BASE, 2'h3, d, k);
		chk(d, 16'h8100);
		report_and_stop();
	end
endmodule : test_pmes_event_status_bank
